// ==== rtl/sdrcfg_ctrl.v ====
`timescale 1ns/10ps
`include "sdrcfg_map.vh"
module sdrcfg_ctrl (
   input wire i_sys_clk,
   input wire i_reset,
   input wire i_clk_en,
   // wishbone register slave
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [7:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   // system memory access port, word address
   input wire i_mem_req,
   input wire i_mem_we,
   input wire [25:0] i_mem_addr,
   input wire [31:0] i_mem_wdata,
   output reg o_mem_ack,
   output reg [31:0] o_mem_rdata,
   output wire o_mem_busy,
   // sdram pins
   output reg o_sd_cs_n,
   output reg o_sd_ras_n,
   output reg o_sd_cas_n,
   output reg o_sd_we_n,
   output reg o_sd_cke,
   output reg [12:0] o_sd_addr,
   output reg [1:0] o_sd_ba,
   input wire [31:0] i_sd_dq,
   output reg [31:0] o_sd_dq,
   output reg o_sd_dq_oe_n,
   // refresh error level, visible also in the status register
   output wire o_refresh_err
);
   // one-hot states
   localparam [8:0] ST_IDLE = 9'h001;
   localparam [8:0] ST_RW = 9'h002;
   localparam [8:0] ST_DATA = 9'h004;
   localparam [8:0] ST_PRE = 9'h008;
   localparam [8:0] ST_WAIT = 9'h010;
   localparam [8:0] ST_DPD = 9'h020;
   localparam [8:0] ST_ACKW = 9'h040;
   localparam [8:0] ST_RCDW = 9'h080;
   localparam [8:0] ST_XSR = 9'h100;

   reg [2:0] mode_r;
   reg [11:0] refr_cnt_r;
   reg [31:0] cfg_r;
   reg [31:0] lpwr_r;
   reg [1:0] mdev_r;
   reg imsk_r;
   reg ists_r;
   reg armed_r;
   reg [11:0] timer_r;
   reg ref_pend_r;
   reg [8:0] state_r;
   reg [8:0] ret_r;
   reg [3:0] cnt_r;
   reg [3:0] ras_cnt_r;
   reg [12:0] col_r;
   reg we_r;

   // number of column bits, 8..11
   function [4:0] col_bits;
      input [1:0] code;
      begin
         col_bits = `SDRCFG_COL_BASE + {3'h0, code};
      end
   endfunction

   // mask of n low bits in a 26-bit word address
   function [25:0] low_mask;
      input [4:0] n;
      begin
         low_mask = ~(26'h3ffffff << n);
      end
   endfunction

   // cas latency in cycles; the reserved code is run as one cycle
   function [3:0] cas_cycles;
      input [1:0] code;
      begin
         cas_cycles = (code == 2'h0) ? 4'h1 : {2'h0, code};
      end
   endfunction

   wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire wb_wr = wb_req & i_wb_we;
   wire [4:0] nc = col_bits(cfg_r[`SDRCFG_F_NC]);
   wire [4:0] nbb = cfg_r[`SDRCFG_F_NB] ? 5'h02 : 5'h01;
   // row code 11 is reserved; it is run as 13 bits
   wire [4:0] nr = (cfg_r[`SDRCFG_F_NR] == 2'h3) ? 5'h0d :
      (`SDRCFG_ROW_BASE + {3'h0, cfg_r[`SDRCFG_F_NR]});
   wire [25:0] col_w = i_mem_addr & low_mask(nc);
   wire [25:0] bank_w = (i_mem_addr >> nc) & low_mask(nbb);
   wire [25:0] row_w = (i_mem_addr >> (nc + nbb)) & low_mask(nr);
   wire refresh_hit = armed_r && (timer_r == 12'h000);

   assign o_mem_busy = ~state_r[0];
   assign o_refresh_err = ists_r;

   // write data merged under byte selects
   function [31:0] merge;
      input [31:0] old;
      input [31:0] din;
      input [3:0] sel;
      begin
         merge = {sel[3] ? din[31:24] : old[31:24], sel[2] ? din[23:16] : old[23:16],
            sel[1] ? din[15:8] : old[15:8], sel[0] ? din[7:0] : old[7:0]};
      end
   endfunction

   // refresh count after a write on the current lanes; only the low 12 bits are kept
   wire [31:0] refr_merged = merge({20'h00000, refr_cnt_r}, i_wb_dat, i_wb_sel);

   // register file; ack one cycle after the request, then dropped
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         mode_r <= 3'h0;
         refr_cnt_r <= 12'h000;
         cfg_r <= `SDRCFG_CFG_RST;
         lpwr_r <= 32'h00000000;
         mdev_r <= 2'h0;
         imsk_r <= 1'b0;
         armed_r <= 1'b0;
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else if (i_clk_en) begin
         o_wb_ack <= wb_req;
         o_wb_dat <= 32'h00000000;
         if (wb_wr) begin
            case (i_wb_adr)
               `SDRCFG_OFS_MODE: mode_r <= i_wb_sel[0] ? i_wb_dat[2:0] : mode_r;
               `SDRCFG_OFS_REFR: begin
                  refr_cnt_r <= refr_merged[11:0];
                  armed_r <= armed_r | i_wb_sel[0] | i_wb_sel[1];
               end
               `SDRCFG_OFS_CFG: cfg_r <= merge(cfg_r, i_wb_dat, i_wb_sel);
               `SDRCFG_OFS_LPWR: lpwr_r <= merge(lpwr_r, i_wb_dat, i_wb_sel) & `SDRCFG_LPWR_MASK;
               `SDRCFG_OFS_IEN: imsk_r <= imsk_r | (i_wb_sel[0] & i_wb_dat[0]);
               `SDRCFG_OFS_IDIS: imsk_r <= imsk_r & ~(i_wb_sel[0] & i_wb_dat[0]);
               `SDRCFG_OFS_MDEV: mdev_r <= i_wb_sel[0] ? i_wb_dat[1:0] : mdev_r;
               default: mode_r <= mode_r;
            endcase
         end else if (wb_req) begin
            case (i_wb_adr)
               `SDRCFG_OFS_MODE: o_wb_dat <= {29'h00000000, mode_r};
               `SDRCFG_OFS_REFR: o_wb_dat <= {20'h00000, refr_cnt_r};
               `SDRCFG_OFS_CFG: o_wb_dat <= cfg_r;
               `SDRCFG_OFS_LPWR: o_wb_dat <= lpwr_r;
               `SDRCFG_OFS_IMSK: o_wb_dat <= {31'h00000000, imsk_r};
               `SDRCFG_OFS_ISTS: o_wb_dat <= {31'h00000000, ists_r};
               `SDRCFG_OFS_MDEV: o_wb_dat <= {30'h00000000, mdev_r};
               default: o_wb_dat <= 32'h00000000;
            endcase
         end
      end
   end

   // refresh timer and error flag; a new error wins over the clear by read
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         timer_r <= 12'h000;
         ref_pend_r <= 1'b0;
         ists_r <= 1'b0;
      end else if (i_clk_en) begin
         if (!armed_r) begin
            // preload the value being written, so arming does not fire an instant refresh
            timer_r <= refr_merged[11:0];
         end else if (refresh_hit) begin
            timer_r <= refr_cnt_r;
         end else begin
            timer_r <= timer_r - 12'h001;
         end
         if (refresh_hit && ref_pend_r) begin
            ists_r <= 1'b1;
         end else if (wb_req && !i_wb_we && i_wb_adr == `SDRCFG_OFS_ISTS) begin
            ists_r <= 1'b0;
         end
         if (refresh_hit) begin
            ref_pend_r <= 1'b1;
         end else if (state_r == ST_IDLE && ref_pend_r && o_sd_cke) begin
            ref_pend_r <= 1'b0;
         end
      end
   end

   // command sequencer; rows are closed after every access, so refresh needs no precharge
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         state_r <= ST_IDLE;
         ret_r <= ST_IDLE;
         cnt_r <= 4'h0;
         ras_cnt_r <= 4'h0;
         col_r <= 13'h0000;
         we_r <= 1'b0;
         {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_NOP;
         o_sd_cke <= 1'b1;
         o_sd_addr <= 13'h0000;
         o_sd_ba <= 2'h0;
         o_sd_dq <= 32'h00000000;
         o_sd_dq_oe_n <= 1'b1;
         o_mem_ack <= 1'b0;
         o_mem_rdata <= 32'h00000000;
      end else if (i_clk_en) begin
         {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_NOP;
         o_mem_ack <= 1'b0;
         o_sd_dq_oe_n <= 1'b1;
         if (ras_cnt_r != 4'h0) begin
            ras_cnt_r <= ras_cnt_r - 4'h1;
         end
         case (state_r)
            ST_IDLE: begin
               if (ref_pend_r) begin
                  {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_REF;
                  cnt_r <= cfg_r[`SDRCFG_F_RC];
                  ret_r <= ST_IDLE;
                  state_r <= ST_WAIT;
               end else if (i_mem_req) begin
                  // the stored mode acts on this access
                  o_sd_addr <= i_mem_addr[12:0];
                  o_sd_ba <= 2'h0;
                  cnt_r <= 4'h0;
                  ret_r <= ST_ACKW;
                  state_r <= ST_WAIT;
                  case (mode_r)
                     `SDRCFG_M_NORMAL: begin
                        {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_ACT;
                        o_sd_addr <= row_w[12:0];
                        o_sd_ba <= bank_w[1:0];
                        col_r <= col_w[12:0];
                        we_r <= i_mem_we;
                        ras_cnt_r <= cfg_r[`SDRCFG_F_RAS];
                        // the column state itself takes one cycle, so wait one less
                        cnt_r <= cfg_r[`SDRCFG_F_RCD] - 4'h1;
                        ret_r <= ST_RW;
                        if (cfg_r[`SDRCFG_F_RCD] <= 4'h1) begin
                           state_r <= ST_RW;
                        end
                     end
                     `SDRCFG_M_NOP: begin
                        {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_NOP;
                     end
                     `SDRCFG_M_PALL: begin
                        {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_PRE;
                        o_sd_addr[`SDRCFG_A10] <= 1'b1;
                        cnt_r <= cfg_r[`SDRCFG_F_RP];
                     end
                     `SDRCFG_M_LMR: begin
                        {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_LMR;
                     end
                     `SDRCFG_M_AREF: begin
                        {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_REF;
                        cnt_r <= cfg_r[`SDRCFG_F_RC];
                     end
                     `SDRCFG_M_EMR: begin
                        {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_LMR;
                        o_sd_ba <= i_mem_addr[14:13];
                     end
                     `SDRCFG_M_DPD: begin
                        {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_DPD;
                        o_sd_cke <= 1'b0;
                        o_mem_ack <= 1'b1;
                        state_r <= ST_DPD;
                     end
                     default: begin
                        {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_NOP;
                     end
                  endcase
               end
            end
            ST_RW: begin
               o_sd_addr <= col_r;
               o_sd_addr[`SDRCFG_A10] <= 1'b0;
               if (we_r) begin
                  {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_WR;
                  o_sd_dq <= cfg_r[`SDRCFG_F_DBW] ? {16'h0000, i_mem_wdata[15:0]} : i_mem_wdata;
                  o_sd_dq_oe_n <= 1'b0;
                  o_mem_ack <= 1'b1;
                  cnt_r <= cfg_r[`SDRCFG_F_WR];
                  ret_r <= ST_PRE;
               end else begin
                  {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_RD;
                  cnt_r <= cas_cycles(cfg_r[`SDRCFG_F_CAS]) - 4'h1;
                  ret_r <= ST_DATA;
               end
               state_r <= ST_WAIT;
            end
            ST_DATA: begin
               o_mem_rdata <= cfg_r[`SDRCFG_F_DBW] ? {16'h0000, i_sd_dq[15:0]} : i_sd_dq;
               o_mem_ack <= 1'b1;
               state_r <= ST_PRE;
            end
            ST_PRE: begin
               // the row stays open until the active time has run out
               if (ras_cnt_r == 4'h0) begin
                  {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n} <= `SDRCFG_C_PRE;
                  o_sd_addr[`SDRCFG_A10] <= 1'b1;
                  cnt_r <= cfg_r[`SDRCFG_F_RP];
                  ret_r <= ST_IDLE;
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (cnt_r <= 4'h1) begin
                  state_r <= ret_r;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            ST_ACKW: begin
               o_mem_ack <= 1'b1;
               state_r <= ST_RCDW;
            end
            ST_RCDW: begin
               // gives the master a cycle to drop its request
               state_r <= ST_IDLE;
            end
            ST_DPD: begin
               // leave power-down only once software selects another mode
               if (mode_r != `SDRCFG_M_DPD && !o_mem_ack) begin
                  o_sd_cke <= 1'b1;
                  cnt_r <= cfg_r[`SDRCFG_F_XSR];
                  state_r <= ST_XSR;
               end
            end
            ST_XSR: begin
               ret_r <= ST_IDLE;
               state_r <= ST_WAIT;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule

// ==== rtl/sdrcfg_map.vh ====
// Operation
// - the three-bit command mode picks the command driven on the next memory access
// - a new mode acts on the following access to memory; software follows with a write
// - mode 000: each access runs as a normal read or write
// - mode 001: each access drives a no-operation command
// - mode 010: each access drives a precharge of all banks
// - mode 011: each access loads the mode register from access address bits
// - mode 100: each access drives auto-refresh; software precharges all banks first
// - mode 101: each access loads the extended mode register in the addressed bank
// - mode 110: the access puts the memory into deep power-down
// - the 12-bit refresh count loads a down-timer; each expiry starts one refresh; an expiry with a refresh still pending starts none and sets the error flag
// - no refresh other than a mode 100 access is issued before software writes the refresh count
// - column code 00..11 gives 8..11 column bits, reset 8
// - row code 00..10 gives 11..13 row bits, reset 11, code 11 reserved
// - bank bit clear means two banks, set means four, reset two
// - latency code 01..11 gives 1..3 read cycles, reset 2, code 00 reserved
// - bus width bit clear means 32-bit data, set means 16-bit, reset 16-bit
// - write recovery field 0..15 cycles, reset 2
// - row cycle field 0..15 cycles from refresh to activate, reset 7
// - precharge delay 0..15 cycles before any next command, reset 3
// - row to column delay 0..15 cycles from activate to read or write, reset 2
// - activate to precharge delay 0..15 cycles, reset 5
// - exit delay 0..15 cycles from clock enable high to activate, reset 8
`ifndef SDRCFG_MAP_VH
`define SDRCFG_MAP_VH
// register byte offsets
`define SDRCFG_OFS_MODE 8'h00
`define SDRCFG_OFS_REFR 8'h04
`define SDRCFG_OFS_CFG 8'h08
`define SDRCFG_OFS_LPWR 8'h10
`define SDRCFG_OFS_IEN 8'h14
`define SDRCFG_OFS_IDIS 8'h18
`define SDRCFG_OFS_IMSK 8'h1c
`define SDRCFG_OFS_ISTS 8'h20
`define SDRCFG_OFS_MDEV 8'h24
// reset values and writable masks
`define SDRCFG_CFG_RST 32'h852372c0
`define SDRCFG_LPWR_MASK 32'h00003f73
// configuration fields
`define SDRCFG_F_XSR 31:28
`define SDRCFG_F_RAS 27:24
`define SDRCFG_F_RCD 23:20
`define SDRCFG_F_RP 19:16
`define SDRCFG_F_RC 15:12
`define SDRCFG_F_WR 11:8
`define SDRCFG_F_DBW 7
`define SDRCFG_F_CAS 6:5
`define SDRCFG_F_NB 4
`define SDRCFG_F_NR 3:2
`define SDRCFG_F_NC 1:0
// command modes
`define SDRCFG_M_NORMAL 3'h0
`define SDRCFG_M_NOP 3'h1
`define SDRCFG_M_PALL 3'h2
`define SDRCFG_M_LMR 3'h3
`define SDRCFG_M_AREF 3'h4
`define SDRCFG_M_EMR 3'h5
`define SDRCFG_M_DPD 3'h6
// {cs_n, ras_n, cas_n, we_n}
`define SDRCFG_C_NOP 4'h7
`define SDRCFG_C_ACT 4'h3
`define SDRCFG_C_RD 4'h5
`define SDRCFG_C_WR 4'h4
`define SDRCFG_C_PRE 4'h2
`define SDRCFG_C_REF 4'h1
`define SDRCFG_C_LMR 4'h0
`define SDRCFG_C_DPD 4'h6
// geometry bases
`define SDRCFG_COL_BASE 5'h08
`define SDRCFG_ROW_BASE 5'h0b
`define SDRCFG_A10 10
`endif

// ==== bench/sdrcfg_ctrl_assertions.sv ====
`timescale 1ns/10ps
`include "sdrcfg_map.vh"
module sdrcfg_ctrl_chk (
   input wire i_sys_clk,
   input wire i_reset,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [7:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   input wire o_wb_ack,
   input wire o_mem_ack,
   input wire o_sd_cs_n,
   input wire o_sd_ras_n,
   input wire o_sd_cas_n,
   input wire o_sd_we_n,
   input wire o_sd_cke,
   input wire [12:0] o_sd_addr,
   input wire [1:0] o_sd_ba,
   input wire o_sd_dq_oe_n
);
   wire [3:0] cmd = {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n};
   wire take = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
   reg [2:0] mode_r;
   reg [3:0] rcd_r;
   reg armed_r;
   reg [4:0] since_r;
   // shadows updated on the taking edge, same edge as the slave stores
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         mode_r <= 3'h0;
         rcd_r <= 4'h2;
         armed_r <= 1'b0;
         since_r <= 5'h00;
      end else begin
         if (take && i_wb_adr == 8'h00 && i_wb_sel[0]) mode_r <= i_wb_dat[2:0];
         if (take && i_wb_adr == 8'h08 && i_wb_sel[2]) rcd_r <= i_wb_dat[23:20];
         if (take && i_wb_adr == 8'h04 && |i_wb_sel[1:0]) armed_r <= 1'b1;
         // saturates so a stale activate never wraps into a match
         if (cmd == `SDRCFG_C_ACT) since_r <= 5'h01;
         else if (since_r != 5'h00 && since_r != 5'h1f) since_r <= since_r + 5'h01;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   sequence s_take;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_dpd;
      cmd == `SDRCFG_C_DPD;
   endsequence
   AST_WB_ANSWER: assert property (s_take |=> o_wb_ack) else $error("wb ack late");
   AST_WB_PULSE: assert property (o_wb_ack |=> !o_wb_ack) else $error("wb ack long");
   AST_MEM_PULSE: assert property (o_mem_ack |=> !o_mem_ack) else $error("mem ack long");
   AST_NO_EARLY_REF: assert property (!armed_r && mode_r != `SDRCFG_M_AREF |-> cmd != `SDRCFG_C_REF)
      else $error("refresh before count written");
   AST_OE_WITH_WR: assert property (!o_sd_dq_oe_n |-> cmd == `SDRCFG_C_WR) else $error("dq driven off write");
   AST_RCD: assert property (cmd == `SDRCFG_C_RD || cmd == `SDRCFG_C_WR |->
      since_r == {1'b0, (rcd_r == 4'h0) ? 4'h1 : rcd_r}) else $error("activate to column spacing");
   AST_DPD_CKE: assert property (s_dpd |=> !o_sd_cke [*3]) else $error("cke high in power-down");
   AST_PALL_A10: assert property (cmd == `SDRCFG_C_PRE |-> o_sd_addr[10]) else $error("precharge not all");
   AST_LMR_BANK: assert property (cmd == `SDRCFG_C_LMR && mode_r == `SDRCFG_M_LMR |-> o_sd_ba == 2'h0)
      else $error("mode load bank");
endmodule
bind sdrcfg_ctrl sdrcfg_ctrl_chk sdrcfg_ctrl_chk_i (.i_sys_clk, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we,
   .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack, .o_mem_ack, .o_sd_cs_n, .o_sd_ras_n, .o_sd_cas_n, .o_sd_we_n,
   .o_sd_cke, .o_sd_addr, .o_sd_ba, .o_sd_dq_oe_n);

// ==== bench/sdrcfg_mem_model.sv ====
`timescale 1ns/10ps
`include "sdrcfg_map.vh"
module sdrcfg_mem_model #(parameter CL = 2) (
   input wire i_sys_clk,
   input wire [3:0] i_cmd,
   input wire [12:0] i_addr,
   input wire [1:0] i_ba,
   input wire [31:0] i_dq,
   input wire i_dq_oe_n,
   output wire [31:0] o_dq
);
   reg [31:0] mem_r [0:1023];
   reg [31:0] last_r = 32'h0;
   reg [2:0] win_r = 3'h0;
   reg [9:0] idx_r = 10'h000;
   wire rd_now = (i_cmd == `SDRCFG_C_RD);
   // store on the write command, read window of CL cycles from the read command
   always @(posedge i_sys_clk) begin
      if (i_cmd == `SDRCFG_C_WR && !i_dq_oe_n) mem_r[{i_ba, i_addr[7:0]}] <= i_dq;
      if (rd_now) win_r <= CL;
      else if (win_r != 3'h0) win_r <= win_r - 3'h1;
      if (rd_now) idx_r <= {i_ba, i_addr[7:0]};
      last_r <= o_dq;
   end
   // outside the window the lines toggle so stale data never passes
   assign o_dq = rd_now ? mem_r[{i_ba, i_addr[7:0]}] : (win_r != 3'h0) ? mem_r[idx_r] : ~last_r;
endmodule

// ==== bench/sdrcfg_ctrl_test.sv ====
`timescale 1ns/10ps
`include "sdrcfg_map.vh"
module sdrcfg_ctrl_test;
   reg i_sys_clk = 1'b0;
   reg i_reset = 1'b1;
   reg i_wb_cyc = 1'b0;
   reg i_wb_stb = 1'b0;
   reg i_wb_we = 1'b0;
   reg [7:0] i_wb_adr = 8'h00;
   reg [31:0] i_wb_dat = 32'h0;
   reg i_mem_req = 1'b0;
   reg i_mem_we = 1'b0;
   reg [25:0] i_mem_addr = 26'h0;
   reg [31:0] i_mem_wdata = 32'h0;
   wire [31:0] o_wb_dat, o_mem_rdata, o_sd_dq, i_sd_dq;
   wire o_wb_ack, o_mem_ack, o_mem_busy, o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n, o_sd_cke;
   wire o_sd_dq_oe_n, o_refresh_err;
   wire [12:0] o_sd_addr;
   wire [1:0] o_sd_ba;
   wire [3:0] cmd = {o_sd_cs_n, o_sd_ras_n, o_sd_cas_n, o_sd_we_n};
   integer fails = 0;
   integer n_compared = 0;
   integer cycles = 0;
   integer k;
   reg [31:0] r, seed;
   reg [31:0] exp_w [$];
   reg [19:0] exp_c [$];
   reg [7:0] ofs [0:7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h1c, 8'h20, 8'h24, 8'h28};
   reg [3:0] fcmd [1:6] = '{4'h7, `SDRCFG_C_PRE, `SDRCFG_C_LMR, `SDRCFG_C_REF, `SDRCFG_C_LMR, `SDRCFG_C_DPD};
   sdrcfg_ctrl sdrcfg_ctrl_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_clk_en(1'b1), .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(4'hf), .i_wb_dat(i_wb_dat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_mem_req(i_mem_req), .i_mem_we(i_mem_we),
      .i_mem_addr(i_mem_addr), .i_mem_wdata(i_mem_wdata), .o_mem_ack(o_mem_ack), .o_mem_rdata(o_mem_rdata),
      .o_mem_busy(o_mem_busy), .o_sd_cs_n(o_sd_cs_n), .o_sd_ras_n(o_sd_ras_n), .o_sd_cas_n(o_sd_cas_n),
      .o_sd_we_n(o_sd_we_n), .o_sd_cke(o_sd_cke), .o_sd_addr(o_sd_addr), .o_sd_ba(o_sd_ba), .i_sd_dq(i_sd_dq),
      .o_sd_dq(o_sd_dq), .o_sd_dq_oe_n(o_sd_dq_oe_n), .o_refresh_err(o_refresh_err));
   sdrcfg_mem_model sdrcfg_mem_model_i (.i_sys_clk(i_sys_clk), .i_cmd(cmd), .i_addr(o_sd_addr), .i_ba(o_sd_ba),
      .i_dq(o_sd_dq), .i_dq_oe_n(o_sd_dq_oe_n), .o_dq(i_sd_dq));
   // 100 ns period
   initial begin
      forever #50 i_sys_clk = ~i_sys_clk;
   end
   task cmp_word(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_compared++;
         if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task cmp_cmd(input [19:0] e);
      begin
         n_compared++;
         if (cmd !== e[19:16] || (e[15] && {o_sd_ba, o_sd_addr} !== e[14:0])) begin
            fails++;
            $display("BAD sd_cmd expected %h seen %h", e, {cmd, 1'b1, o_sd_ba, o_sd_addr});
         end
      end
   endtask
   task final_report;
      begin
         $display("compared %0d mismatches %0d", n_compared, fails);
         if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // one register cycle; the request holds until ack is sampled
   task wb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge i_sys_clk);
         {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, a, d};
         @(negedge i_sys_clk);
         while (o_wb_ack !== 1'b1) @(negedge i_sys_clk);
         @(posedge i_sys_clk);
         {i_wb_cyc, i_wb_stb} <= 2'b00;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         exp_w.push_back(e);
         wb(1'b0, a, 32'h0);
      end
   endtask
   // memory access; waits for the sequencer to go idle first
   task mem(input w, input [25:0] a, input [31:0] d);
      begin
         while (o_mem_busy !== 1'b0) @(negedge i_sys_clk);
         @(posedge i_sys_clk);
         {i_mem_req, i_mem_we, i_mem_addr, i_mem_wdata} <= {1'b1, w, a, d};
         @(negedge i_sys_clk);
         while (o_mem_ack !== 1'b1) @(negedge i_sys_clk);
         @(posedge i_sys_clk);
         i_mem_req <= 1'b0;
      end
   endtask
   // normal access: activate, column command, closing precharge
   task norm(input w, input [25:0] a, input [31:0] d, input [31:0] e);
      begin
         exp_c.push_back({`SDRCFG_C_ACT, 16'h0});
         exp_c.push_back({w ? `SDRCFG_C_WR : `SDRCFG_C_RD, 16'h0});
         exp_c.push_back({`SDRCFG_C_PRE, 16'h0});
         if (!w) exp_w.push_back(e);
         mem(w, a, d);
      end
   endtask
   // results are compared in order against the oldest note
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         final_report;
      end
      if (!i_reset && o_wb_ack === 1'b1 && !i_wb_we) cmp_word("wb_dat", exp_w.size() ? exp_w.pop_front() : 'x, o_wb_dat);
      if (!i_reset && o_mem_ack === 1'b1 && !i_mem_we) cmp_word("rdata", exp_w.size() ? exp_w.pop_front() : 'x, o_mem_rdata);
      if (!i_reset && cmd !== `SDRCFG_C_NOP) cmp_cmd(exp_c.size() ? exp_c.pop_front() : 'x);
   end
   initial begin
      seed = $urandom(32'he3bcbaaa);
      repeat (16) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      for (k = 0; k < 8; k++) rd(ofs[k], ofs[k] == 8'h08 ? `SDRCFG_CFG_RST : 32'h0);
      r = $urandom;
      wb(1'b1, 8'h08, r);
      rd(8'h08, r);
      wb(1'b1, 8'h08, `SDRCFG_CFG_RST);
      // forced modes in order, precharge ahead of auto-refresh
      for (k = 1; k < 7; k++) begin
         wb(1'b1, 8'h00, {29'h1fffffff, k[2:0]});
         rd(8'h00, k);
         if (k == 3) exp_c.push_back({fcmd[k], 16'h8031});
         else if (k == 5) exp_c.push_back({fcmd[k], 16'ha031});
         else if (k != 1) exp_c.push_back({fcmd[k], 16'h0});
         mem(1'b1, 26'h2031, $urandom);
      end
      wb(1'b1, 8'h00, 32'h0);
      for (k = 1; k < 3; k++) begin
         r = $urandom;
         norm(1'b1, k, r, 0);
         norm(1'b1, k + 4, ~r, 0);
         norm(1'b0, k, 0, {16'h0, r[15:0]});
      end
      wb(1'b1, 8'h08, `SDRCFG_CFG_RST & 32'hffffff7f);
      r = $urandom;
      norm(1'b1, 26'h3, r, 0);
      norm(1'b0, 26'h3, 0, r);
      // arm refresh last: one refresh expected before the second expiry
      exp_c.push_back({`SDRCFG_C_REF, 16'h0});
      wb(1'b1, 8'h04, 32'hfffff020);
      rd(8'h04, 32'h020);
      repeat (45) @(posedge i_sys_clk);
      rd(8'h20, 32'h0);
      cmp_word("cmd_left", 0, exp_c.size());
      final_report;
   end
endmodule
